/* verilog/sacs_top.v */
// serial adapter control and status logic with receive buffer
// assumes all pins asynchronous to CLK_SYS and much slower than it
`timescale 1ns/1ns
`default_nettype none
`include "sacs_defs.vh"

////////////////////////////////////////////////////////////////////////////////
module sacs_fifo #(
	parameter W  = `SACS_FIFO_WIDTH,
	parameter D  = `SACS_FIFO_DEPTH,
	parameter AW = `SACS_FIFO_AW
) (
	input  wire         clk,
	input  wire         rstn,
	input  wire         clr,
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wp;
	reg [AW-1:0] rp;
	reg [AW:0]   cnt;
	wire         push;
	wire         pop;

	assign in_ready  = (cnt != D[AW:0]);
	assign out_valid = (cnt != {(AW+1){1'b0}});
	assign out_data  = mem[rp];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @(posedge clk)
	begin
		if (push)
			mem[wp] <= in_data;
	end

	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wp  <= {AW{1'b0}};
			rp  <= {AW{1'b0}};
			cnt <= {(AW+1){1'b0}};
		end
		else if (clr)
		begin
			wp  <= {AW{1'b0}};
			rp  <= {AW{1'b0}};
			cnt <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wp <= wp + 1'b1;
			if (pop)
				rp <= rp + 1'b1;
			if (push & ~pop)
				cnt <= cnt + 1'b1;
			else if (pop & ~push)
				cnt <= cnt - 1'b1;
		end
	end
endmodule // sacs_fifo

////////////////////////////////////////////////////////////////////////////////
module sacs_top (
	input  wire       CLK_SYS,
	input  wire       RSTN,
	input  wire       E,
	input  wire       CS_N,
	input  wire       REGISTER_SELECT,
	input  wire       RW,
	input  wire [7:0] D_IN,
	output reg  [7:0] D_OUT,
	output reg        D_OE,
	input  wire       RX_CLK,
	input  wire       TX_CLK,
	input  wire       RXD,
	input  wire       CTS_N,
	input  wire       CARRIER_LOST_INPUT,
	output reg        TXD,
	output reg        RTS_N,
	output reg        IRQ_N
);
	localparam RX_IDLE  = 3'b001;
	localparam RX_START = 3'b010;
	localparam RX_BITS  = 3'b100;
	localparam TX_IDLE  = 2'b01;
	localparam TX_RUN   = 2'b10;

	wire [`SACS_NSYNC-1:0] pin_raw;
	reg  [`SACS_NSYNC-1:0] s1;
	reg  [`SACS_NSYNC-1:0] s2;
	reg  [`SACS_NSYNC-1:0] s3;
	reg  [`SACS_NSYNC-1:0] pin;
	reg  [`SACS_NSYNC-1:0] pin_d;

	////////////////////////////////////////////////////////////////////////
	// three-stage sync; value moves only when stages two and three agree
	assign pin_raw = {D_IN, CARRIER_LOST_INPUT, CTS_N, RXD, TX_CLK, RX_CLK,
		RW, REGISTER_SELECT, CS_N, E};
	genvar g;
	generate
		for (g = 0; g < `SACS_NSYNC; g = g + 1)
		begin : g_sync
			always @(posedge CLK_SYS or negedge RSTN)
			begin
				if (!RSTN)
				begin
					// enable resets to its idle low level: no false strobe edge
					s1[g]    <= (g != `SACS_P_E);
					s2[g]    <= (g != `SACS_P_E);
					s3[g]    <= (g != `SACS_P_E);
					pin[g]   <= (g != `SACS_P_E);
					pin_d[g] <= (g != `SACS_P_E);
				end
				else
				begin
					s1[g]    <= pin_raw[g];
					s2[g]    <= s1[g];
					s3[g]    <= s2[g];
					pin[g]   <= (s2[g] == s3[g]) ? s3[g] : pin[g];
					pin_d[g] <= pin[g];
				end
			end
		end
	endgenerate

	wire       e_rise   = pin[`SACS_P_E] & ~pin_d[`SACS_P_E];
	wire       e_fall   = ~pin[`SACS_P_E] & pin_d[`SACS_P_E];
	wire       sel      = ~pin[`SACS_P_CS_N];
	wire       rs       = pin[`SACS_P_RS];
	wire       rd       = pin[`SACS_P_RW];
	wire [7:0] din      = pin[`SACS_P_DIN +: 8];
	wire       rx_tick  = pin[`SACS_P_RXCLK] & ~pin_d[`SACS_P_RXCLK];
	wire       tx_tick  = ~pin[`SACS_P_TXCLK] & pin_d[`SACS_P_TXCLK];
	wire       rxd      = pin[`SACS_P_RXD];
	wire       cts_high = pin[`SACS_P_CTS_N];
	wire       carrier  = pin[`SACS_P_CARRIER];
	wire       car_rise = carrier & ~pin_d[`SACS_P_CARRIER];

	// bus strobes act on the falling edge of the enable
	wire wr_ctrl = e_fall & sel & (rs == `SACS_RS_CTRL_STAT) & ~rd;
	wire rd_stat = e_fall & sel & (rs == `SACS_RS_CTRL_STAT) & rd;
	wire wr_data = e_fall & sel & (rs == `SACS_RS_DATA) & ~rd;
	wire rd_data = e_fall & sel & (rs == `SACS_RS_DATA) & rd;

	////////////////////////////////////////////////////////////////////////
	reg  [7:0] line_control;
	wire [1:0] div_sel = {line_control[`SACS_DIV_HI], line_control[`SACS_DIV_LO]};
	wire [2:0] word    = line_control[`SACS_WORD_HI:`SACS_WORD_LO];
	wire [1:0] tx_ctl  = line_control[`SACS_TXC_HI:`SACS_TXC_LO];
	wire       rx_irq_enable = line_control[`SACS_RXIE_BIT];
	// held in reset until host picks a real ratio
	wire       mreset  = (div_sel == `SACS_DIV_MRESET);

	// live decode, no buffering of format bits
	wire       len8     = word[2];
	wire       par_en   = ~word[2] | word[1];
	wire       par_odd  = word[0];
	wire       two_stop = ~word[1] & ~(word[2] & word[0]);
	wire [3:0] len      = len8 ? 4'h8 : 4'h7;
	wire [5:0] nm1      = (div_sel == `SACS_DIV_16) ? `SACS_NM1_16 :
		(div_sel == `SACS_DIV_64) ? `SACS_NM1_64 : 6'h00;
	wire [5:0] half     = (div_sel == `SACS_DIV_16) ? `SACS_HALF_16 : `SACS_HALF_64;

	always @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
			line_control <= `SACS_CTRL_RESET;
		else if (wr_ctrl)
			line_control <= din;
	end

	////////////////////////////////////////////////////////////////////////
	// receiver
	reg  [2:0] rx_state;
	reg  [5:0] rx_cnt;
	reg  [3:0] rx_idx;
	reg  [7:0] rx_sh;
	reg        rx_par;
	reg        push;
	reg  [9:0] push_data;
	wire       fifo_ready;
	wire       fifo_valid;
	wire [9:0] fifo_data;
	reg        rx_full;
	reg  [7:0] rx_holding_register;
	reg        frame_error_flag;
	reg        parity_error_flag;
	reg        ovr_pend;
	reg        ovr_shown;
	wire       rx_clr = mreset | carrier;
	wire       load   = fifo_valid & ~rx_full;
	wire [3:0] stop_idx = len + {3'b000, par_en};
	wire       par_bad  = ((^{rx_sh, rx_par}) != par_odd) & par_en;

	always @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			rx_state  <= RX_IDLE;
			rx_cnt    <= 6'h00;
			rx_idx    <= 4'h0;
			rx_sh     <= 8'h00;
			rx_par    <= 1'b0;
			push      <= 1'b0;
			push_data <= 10'h000;
		end
		else if (rx_clr)
		begin
			rx_state <= RX_IDLE;
			push     <= 1'b0;
		end
		else
		begin
			push <= 1'b0;
			if (rx_tick)
			begin
				case (rx_state)
				RX_IDLE:
					if (!rxd)
					begin
						rx_cnt   <= 6'h00;
						rx_idx   <= 4'h0;
						rx_sh    <= 8'h00;
						rx_par   <= 1'b0;
						rx_state <= (div_sel == `SACS_DIV_1) ? RX_BITS : RX_START;
					end
				RX_START:
					if (rx_cnt == half)
					begin
						rx_cnt   <= 6'h00;
						rx_state <= rxd ? RX_IDLE : RX_BITS;
					end
					else
						rx_cnt <= rx_cnt + 6'h01;
				RX_BITS:
					if (rx_cnt == nm1)
					begin
						rx_cnt <= 6'h00;
						rx_idx <= rx_idx + 4'h1;
						if (rx_idx < len)
							rx_sh[rx_idx[2:0]] <= rxd;
						else if (rx_idx < stop_idx)
							rx_par <= rxd;
						else
						begin
							// stop sampled mid-bit; overrun decided by the status logic when this push meets a full buffer
							push      <= 1'b1;
							push_data <= {~rxd, par_bad, rx_sh};
							rx_state  <= RX_IDLE;
						end
					end
					else
						rx_cnt <= rx_cnt + 6'h01;
				default:
					rx_state <= RX_IDLE;
				endcase
			end
		end
	end

	sacs_fifo #(
		.W  (`SACS_FIFO_WIDTH),
		.D  (`SACS_FIFO_DEPTH),
		.AW (`SACS_FIFO_AW)
	) u_rx_fifo (
		.clk       (CLK_SYS),
		.rstn      (RSTN),
		.clr       (rx_clr),
		.in_valid  (push),
		.in_ready  (fifo_ready),
		.in_data   (push_data),
		.out_valid (fifo_valid),
		.out_ready (load),
		.out_data  (fifo_data)
	);

	always @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			rx_full             <= 1'b0;
			rx_holding_register <= 8'h00;
			frame_error_flag    <= 1'b0;
			parity_error_flag   <= 1'b0;
			ovr_pend            <= 1'b0;
			ovr_shown           <= 1'b0;
		end
		else if (rx_clr)
		begin
			rx_full           <= 1'b0;
			frame_error_flag  <= 1'b0;
			parity_error_flag <= 1'b0;
			ovr_pend          <= 1'b0;
			ovr_shown         <= 1'b0;
		end
		else
		begin
			if (rd_data)
			begin
				if (ovr_shown)
				begin
					ovr_shown <= 1'b0;
					ovr_pend  <= 1'b0;
					rx_full   <= 1'b0;
				end
				// flag waits until the last buffered character is read
				else if (ovr_pend & ~fifo_valid)
					ovr_shown <= 1'b1;
				else
					rx_full <= 1'b0;
			end
			// a load wins over a same-cycle read of an empty register
			if (load)
			begin
				rx_full             <= 1'b1;
				rx_holding_register <= fifo_data[7:0];
				frame_error_flag    <= fifo_data[9];
				parity_error_flag   <= fifo_data[8];
			end
			// lost character wins over a same-cycle read
			if (push & ~fifo_ready)
				ovr_pend <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// carrier loss latch, cleared by status read then data read
	reg car_latch;
	reg car_armed;

	always @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			car_latch <= 1'b0;
			car_armed <= 1'b0;
		end
		else if (car_rise)
		begin
			car_latch <= 1'b1;
			car_armed <= 1'b0;
		end
		else if (mreset)
		begin
			car_latch <= 1'b0;
			car_armed <= 1'b0;
		end
		else if (rd_stat & car_latch)
			car_armed <= 1'b1;
		else if (rd_data & car_armed)
		begin
			car_latch <= 1'b0;
			car_armed <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transmitter
	reg  [1:0] tx_state;
	reg  [5:0] tx_cnt;
	reg  [3:0] tx_idx;
	reg  [7:0] tx_holding_register;
	reg  [7:0] tx_sh;
	reg        tx_full;
	wire [7:0] tx_bits  = len8 ? tx_sh : {1'b0, tx_sh[6:0]};
	wire       tx_par   = (^tx_bits) ^ par_odd;
	wire [3:0] tx_pidx  = len + 4'h1;
	wire [3:0] tx_last  = tx_pidx + {3'b000, par_en} + {3'b000, two_stop};
	wire [3:0] tx_didx  = tx_idx - 4'h1;
	reg        tx_bit;

	always @*
	begin
		if (tx_idx == 4'h0)
			tx_bit = 1'b0;
		else if (tx_idx < tx_pidx)
			tx_bit = tx_sh[tx_didx[2:0]];
		else if ((tx_idx == tx_pidx) & par_en)
			tx_bit = tx_par;
		else
			tx_bit = 1'b1;
	end

	always @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			tx_state            <= TX_IDLE;
			tx_cnt              <= 6'h00;
			tx_idx              <= 4'h0;
			tx_sh               <= 8'h00;
			tx_full             <= 1'b0;
			tx_holding_register <= 8'h00;
		end
		else if (mreset)
		begin
			tx_state <= TX_IDLE;
			tx_full  <= 1'b0;
		end
		else
		begin
			if (tx_tick)
			begin
				case (tx_state)
				TX_IDLE:
					if (tx_full)
					begin
						tx_sh    <= tx_holding_register;
						tx_full  <= 1'b0;
						tx_idx   <= 4'h0;
						tx_cnt   <= 6'h00;
						tx_state <= TX_RUN;
					end
				TX_RUN:
					if (tx_cnt == nm1)
					begin
						tx_cnt <= 6'h00;
						if (tx_idx >= tx_last)
							tx_state <= TX_IDLE;
						else
							tx_idx <= tx_idx + 4'h1;
					end
					else
						tx_cnt <= tx_cnt + 6'h01;
				default:
					tx_state <= TX_IDLE;
				endcase
			end
			// host write wins over a same-cycle transfer
			if (wr_data)
			begin
				tx_holding_register <= din;
				tx_full             <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status, interrupt and pins
	wire tx_empty_flag = ~tx_full & ~cts_high;
	wire rx_full_flag  = rx_full & ~carrier;
	wire overrun_flag  = ovr_shown;
	wire irq = (rx_irq_enable & (rx_full_flag | overrun_flag | car_latch))
		| ((tx_ctl == `SACS_TXC_IRQ_ON) & tx_empty_flag);
	wire [7:0] line_status = {~IRQ_N, parity_error_flag, overrun_flag, frame_error_flag,
		cts_high, car_latch | carrier, tx_empty_flag, rx_full_flag};

	always @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			D_OUT <= 8'h00;
			D_OE  <= 1'b0;
			TXD   <= 1'b1;
			RTS_N <= 1'b1;
			IRQ_N <= 1'b1;
		end
		else
		begin
			// the read data is captured on the enable rise; its side-effects act later, on the fall
			if (e_rise & sel & rd)
			begin
				D_OE  <= 1'b1;
				D_OUT <= (rs == `SACS_RS_DATA) ? rx_holding_register : line_status;
			end
			else if (e_fall)
				D_OE <= 1'b0;
			TXD   <= (tx_ctl == `SACS_TXC_BREAK) ? 1'b0 :
				((tx_state == TX_RUN) ? tx_bit : 1'b1);
			RTS_N <= (tx_ctl == `SACS_TXC_RTS_HIGH);
			IRQ_N <= ~irq;
		end
	end
endmodule // sacs_top
`default_nettype wire

/* verilog/sacs_defs.vh */
// constants for the serial adapter control and status block
// assumes a single 125 MHz system clock and an 8-bit host bus on pins
`ifndef SACS_DEFS_VH
`define SACS_DEFS_VH
// register select decode
`define SACS_RS_CTRL_STAT   1'b0
`define SACS_RS_DATA        1'b1
// control fields
`define SACS_DIV_LO         0
`define SACS_DIV_HI         1
`define SACS_WORD_LO        2
`define SACS_WORD_HI        4
`define SACS_TXC_LO         5
`define SACS_TXC_HI         6
`define SACS_RXIE_BIT       7
`define SACS_CTRL_RESET     8'h03
// divide codes
`define SACS_DIV_1          2'h0
`define SACS_DIV_16         2'h1
`define SACS_DIV_64         2'h2
`define SACS_DIV_MRESET     2'h3
// ticks per bit minus one, and to mid start bit
`define SACS_NM1_16         6'h0f
`define SACS_NM1_64         6'h3f
`define SACS_HALF_16        6'h07
`define SACS_HALF_64        6'h1f
// transmitter control codes
`define SACS_TXC_IRQ_ON     2'h1
`define SACS_TXC_RTS_HIGH   2'h2
`define SACS_TXC_BREAK      2'h3
// status bit positions
`define SACS_ST_RXFULL      0
`define SACS_ST_TXEMPTY     1
`define SACS_ST_CARRIER     2
`define SACS_ST_CTS         3
`define SACS_ST_FRAME       4
`define SACS_ST_OVERRUN     5
`define SACS_ST_PARITY      6
`define SACS_ST_IRQ         7
// receive buffer
`define SACS_FIFO_WIDTH     10
`define SACS_FIFO_DEPTH     16
`define SACS_FIFO_AW        4
// synchronised pin vector
`define SACS_NSYNC          17
`define SACS_P_E            0
`define SACS_P_CS_N         1
`define SACS_P_RS           2
`define SACS_P_RW           3
`define SACS_P_RXCLK        4
`define SACS_P_TXCLK        5
`define SACS_P_RXD          6
`define SACS_P_CTS_N        7
`define SACS_P_CARRIER      8
`define SACS_P_DIN          9
`endif

/* bench/sacs_asserts.sv */
// port checker for the serial adapter control and status top
// assumes host pins change just after a CLK_SYS edge and stay put while E is high
`timescale 1ns/1ns
`default_nettype none
module sacs_asserts (
	input wire logic       CLK_SYS,
	input wire logic       RSTN,
	input wire logic       E,
	input wire logic       CS_N,
	input wire logic       REGISTER_SELECT,
	input wire logic       RW,
	input wire logic [7:0] D_IN,
	input wire logic [7:0] D_OUT,
	input wire logic       D_OE,
	input wire logic       TX_CLK,
	input wire logic       CTS_N,
	input wire logic       CARRIER_LOST_INPUT,
	input wire logic       TXD,
	input wire logic       RTS_N,
	input wire logic       IRQ_N
);
	logic [7:0] ctrl;
	logic [4:0] ca;
	logic [3:0] pa;
	logic [3:0] tf;
	// ages let the pin synchroniser settle before the control, modem-line and transmit-clock checks are judged
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			ctrl <= 8'h03;
			ca   <= 5'h00;
			pa   <= 4'h0;
			tf   <= 4'h0;
		end
		else
		begin
			ca <= (ca == 5'h1f) ? ca : ca + 5'h01;
			pa <= (pa == 4'hf) ? pa : pa + 4'h1;
			tf <= (tf == 4'hf) ? tf : tf + 4'h1;
			if ($fell(E) && !CS_N && !REGISTER_SELECT && !RW)
			begin
				ctrl <= D_IN;
				ca   <= 5'h00;
			end
			if ($changed({CTS_N, CARRIER_LOST_INPUT}))
				pa <= 4'h0;
			if ($fell(TX_CLK))
				tf <= 4'h0;
		end
	end
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);
	////////////////////////////////////////
	property p_rts; ca == 5'h1f |-> RTS_N == (ctrl[6:5] == 2'h2); endproperty
	a_rts: assert property (p_rts) else $error("request level wrong");
	property p_brk; ca == 5'h1f && ctrl[6:5] == 2'h3 |-> !TXD && !RTS_N; endproperty
	a_brk: assert property (p_brk) else $error("break level missing");
	property p_mrst; ca == 5'h1f && ctrl[1:0] == 2'h3 && ctrl[6:5] != 2'h3 |-> TXD; endproperty
	a_mrst: assert property (p_mrst) else $error("line not idle in master reset");
	property p_txirq; ca == 5'h1f && !ctrl[7] && ctrl[6:5] != 2'h1 |-> IRQ_N; endproperty
	a_txirq: assert property (p_txirq) else $error("interrupt with no enable");
	property p_oe_up; $rose(E) && !CS_N && RW |-> ##[3:8] D_OE; endproperty
	a_oe_up: assert property (p_oe_up) else $error("read not driven");
	property p_oe_dn; !E [*8] |-> !D_OE; endproperty
	a_oe_dn: assert property (p_oe_dn) else $error("bus driven after enable");
	property p_oe_sel; $rose(D_OE) |-> !CS_N && RW; endproperty
	a_oe_sel: assert property (p_oe_sel) else $error("bus driven unselected");
	property p_st7; $rose(D_OE) && !REGISTER_SELECT && $stable(IRQ_N) |-> D_OUT[7] == !IRQ_N; endproperty
	a_st7: assert property (p_st7) else $error("status irq bit wrong");
	property p_cts; $rose(D_OE) && !REGISTER_SELECT && pa == 4'hf
		|-> D_OUT[3] == CTS_N && (!CTS_N || !D_OUT[1]); endproperty
	a_cts: assert property (p_cts) else $error("clear-to-send status wrong");
	property p_car; $rose(D_OE) && !REGISTER_SELECT && pa == 4'hf && CARRIER_LOST_INPUT
		|-> D_OUT[2] && !D_OUT[0]; endproperty
	a_car: assert property (p_car) else $error("carrier status wrong");
	property p_txclk; $changed(TXD) && ca == 5'h1f |-> tf < 4'hc; endproperty
	a_txclk: assert property (p_txclk) else $error("serial out off falling edge");
endmodule // sacs_asserts
bind sacs_top sacs_asserts chk (
	.CLK_SYS, .RSTN, .E, .CS_N, .REGISTER_SELECT, .RW, .D_IN, .D_OUT, .D_OE,
	.TX_CLK, .CTS_N, .CARRIER_LOST_INPUT, .TXD, .RTS_N, .IRQ_N
);
`default_nettype wire

/* bench/sacs_modem.sv */
// far-side serial model: free-running bit clocks, receive line, transmit capture
// assumes CLK_SYS runs; both bit clocks have a 16-cycle period
`timescale 1ns/1ns
`default_nettype none
module sacs_modem (
	input  wire logic CLK_SYS,
	input  wire logic TXD,
	output var  logic RX_CLK,
	output var  logic TX_CLK,
	output var  logic RXD
);
	logic [3:0] cnt;
	initial
	begin
		cnt = 4'h0;
		RX_CLK = 1'h0;
		TX_CLK = 1'h0;
		RXD = 1'h1;
	end
	always @(posedge CLK_SYS)
	begin
		cnt <= cnt + 4'h1;
		RX_CLK <= cnt[3];
		TX_CLK <= cnt[3];
	end
	////////////////////////////////////////
	// data moves on the falling edge so it is settled at the sampling edge
	task automatic send(input logic [11:0] b, input int n, input int m);
		for (int i = 0; i < n; i++)
		begin
			@(negedge RX_CLK);
			RXD <= b[i];
			repeat (m - 1) @(negedge RX_CLK);
		end
		@(negedge RX_CLK);
		RXD <= 1'h1;
		repeat (m) @(posedge RX_CLK);
	endtask
	task automatic recv(input int n, output logic [11:0] b);
		int k;
		k = 0;
		b = 12'hffe;
		do
		begin
			@(posedge TX_CLK);
			k++;
		end
		while (TXD !== 1'h0 && k < 64);
		// no start bit within the bound: poison the frame so the compare fails
		if (TXD !== 1'h0)
			b[0] = 1'hx;
		for (int i = 1; i < n; i++)
		begin
			@(posedge TX_CLK);
			b[i] = TXD;
		end
	endtask
endmodule // sacs_modem
`default_nettype wire

/* bench/sacs_top_test.sv */
// self-checking bench for the serial adapter control and status top
// assumes the modem model and the bound port checker beside it
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", nm, e, a); end end
module sacs_top_test;
	logic        CLK_SYS = 1'h0;
	logic        RSTN = 1'h0;
	logic        E = 1'h0;
	logic        CS_N = 1'h1;
	logic        REGISTER_SELECT = 1'h0;
	logic        RW = 1'h1;
	logic [7:0]  D_IN = 8'h00;
	logic        CTS_N = 1'h0;
	logic        CARRIER_LOST_INPUT = 1'h0;
	wire  [7:0]  D_OUT;
	wire         D_OE;
	wire         RX_CLK;
	wire         TX_CLK;
	wire         RXD;
	wire         TXD;
	wire         RTS_N;
	wire         IRQ_N;
	int          err_total = 0;
	int          n_tests = 0;
	int          n;
	logic [7:0]  q;
	logic [7:0]  d;
	logic        pe;
	logic        fe;
	logic [11:0] fb;
	logic [11:0] rb;
	logic [7:0]  hist [0:17];
	always #4 CLK_SYS = ~CLK_SYS;
	sacs_top dut (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .E(E), .CS_N(CS_N),
		.REGISTER_SELECT(REGISTER_SELECT), .RW(RW), .D_IN(D_IN), .D_OUT(D_OUT),
		.D_OE(D_OE), .RX_CLK(RX_CLK), .TX_CLK(TX_CLK), .RXD(RXD), .CTS_N(CTS_N),
		.CARRIER_LOST_INPUT(CARRIER_LOST_INPUT), .TXD(TXD), .RTS_N(RTS_N), .IRQ_N(IRQ_N));
	sacs_modem modem (.CLK_SYS(CLK_SYS), .TXD(TXD), .RX_CLK(RX_CLK), .TX_CLK(TX_CLK), .RXD(RXD));
	////////////////////////////////////////
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// select and data held well past enable fall: the pins are filtered slowly
	task automatic bus(input logic rs, input logic rw, input logic [7:0] v);
		CS_N <= 1'h0;
		REGISTER_SELECT <= rs;
		RW <= rw;
		D_IN <= v;
		@(posedge CLK_SYS);
		E <= 1'h1;
		repeat (10) @(posedge CLK_SYS);
		if (rw) `CHK("bus drive", 1'h1, D_OE)
		q = D_OUT;
		E <= 1'h0;
		repeat (9) @(posedge CLK_SYS);
		CS_N <= 1'h1;
		@(posedge CLK_SYS);
	endtask
	function automatic logic [11:0] frm(input logic [2:0] f, input logic [7:0] v,
		input logic pe, input logic fe, output int n);
		logic [11:0] b;
		int w;
		w = f[2] ? 8 : 7;
		b = 12'hffe;
		for (int i = 0; i < w; i++)
			b[i + 1] = v[i];
		n = w + 1;
		if (f[2:1] != 2'h2)
		begin
			b[n] = (f[2] ? ^v : ^v[6:0]) ^ f[0] ^ pe;
			n++;
		end
		b[n] = !fe;
		n = n + ((f == 3'h0 || f == 3'h1 || f == 3'h4) ? 2 : 1);
		return b;
	endfunction
	task automatic rx_char(input logic [7:0] v);
		fb = frm(3'h5, v, 1'h0, 1'h0, n);
		modem.send(fb, n, 1);
		repeat (20) @(posedge CLK_SYS);
	endtask
	initial
	begin
		repeat (40000) @(posedge CLK_SYS);
		err_total++;
		end_of_test;
	end
	initial
	begin
		void'($urandom(32'h97e1));
		repeat (5) @(posedge CLK_SYS);
		RSTN <= 1'h1;
		repeat (8) @(posedge CLK_SYS);
		bus(1'h0, 1'h1, 8'h00);
		`CHK("reset status", 8'h00, q & 8'hfd)
		for (int f = 0; f < 8; f++)
		begin
			d = $urandom;
			pe = $urandom;
			fe = $urandom;
			bus(1'h0, 1'h0, {3'h0, f[2:0], 2'h0});
			fb = frm(f[2:0], d, 1'h0, 1'h0, n);
			fork
				bus(1'h1, 1'h0, d);
				modem.recv(n, rb);
			join
			`CHK("sent frame", fb, rb)
			fb = frm(f[2:0], d, pe, fe, n);
			modem.send(fb, n, 1);
			repeat (20) @(posedge CLK_SYS);
			bus(1'h0, 1'h1, 8'h00);
			`CHK("rx status", {1'h0, pe & (f[2:1] != 2'h2), 1'h0, fe, 4'h3}, q)
			bus(1'h1, 1'h1, 8'h00);
			`CHK("rx data", f[2] ? d : {1'h0, d[6:0]}, q)
		end
		$display("formats done");
		bus(1'h0, 1'h0, 8'h15);
		d = $urandom;
		modem.send(12'h000, 1, 4);
		modem.send(12'hfff, 1, 16);
		fb = frm(3'h5, d, 1'h0, 1'h0, n);
		modem.send(fb, n, 16);
		repeat (20) @(posedge CLK_SYS);
		bus(1'h1, 1'h1, 8'h00);
		`CHK("div16 data", d, q)
		bus(1'h0, 1'h1, 8'h00);
		`CHK("false start", 8'h02, q)
		$display("divide done");
		bus(1'h0, 1'h0, 8'hb4);
		repeat (20) @(posedge CLK_SYS);
		`CHK("tx irq", 1'h0, IRQ_N)
		// second write lands while the first character is still shifting out
		bus(1'h1, 1'h0, 8'h55);
		bus(1'h1, 1'h0, 8'haa);
		`CHK("tx irq released", 1'h1, IRQ_N)
		bus(1'h0, 1'h1, 8'h00);
		`CHK("tx full", 8'h00, q)
		bus(1'h0, 1'h0, 8'h94);
		repeat (20) @(posedge CLK_SYS);
		`CHK("irq idle", 1'h1, IRQ_N)
		d = $urandom;
		rx_char(d);
		`CHK("rx irq", 1'h0, IRQ_N)
		bus(1'h1, 1'h1, 8'h00);
		`CHK("irq data", d, q)
		`CHK("irq released", 1'h1, IRQ_N)
		CARRIER_LOST_INPUT <= 1'h1;
		repeat (20) @(posedge CLK_SYS);
		`CHK("carrier irq", 1'h0, IRQ_N)
		bus(1'h0, 1'h1, 8'h00);
		`CHK("carrier high", 8'h86, q)
		CARRIER_LOST_INPUT <= 1'h0;
		repeat (20) @(posedge CLK_SYS);
		bus(1'h0, 1'h1, 8'h00);
		`CHK("carrier latch", 8'h86, q)
		bus(1'h1, 1'h1, 8'h00);
		bus(1'h0, 1'h1, 8'h00);
		`CHK("carrier cleared", 8'h02, q)
		CTS_N <= 1'h1;
		repeat (20) @(posedge CLK_SYS);
		bus(1'h0, 1'h1, 8'h00);
		`CHK("not clear", 8'h08, q & 8'h0a)
		CTS_N <= 1'h0;
		bus(1'h0, 1'h0, 8'h54);
		repeat (20) @(posedge CLK_SYS);
		`CHK("request high", 1'h1, RTS_N)
		bus(1'h0, 1'h0, 8'h74);
		repeat (40) @(posedge CLK_SYS);
		`CHK("break", 2'h0, {TXD, RTS_N})
		bus(1'h0, 1'h0, 8'h14);
		$display("modem lines done");
		// one held character plus a full buffer, then one more is lost
		for (int i = 0; i < 18; i++)
		begin
			hist[i] = $urandom;
			rx_char(hist[i]);
		end
		for (int i = 0; i < 17; i++)
		begin
			bus(1'h1, 1'h1, 8'h00);
			`CHK("drain", hist[i], q)
		end
		bus(1'h0, 1'h1, 8'h00);
		`CHK("overrun shown", 8'h23, q)
		bus(1'h1, 1'h1, 8'h00);
		bus(1'h0, 1'h1, 8'h00);
		`CHK("overrun cleared", 8'h02, q)
		rx_char(8'h5a);
		bus(1'h0, 1'h0, 8'h17);
		bus(1'h0, 1'h1, 8'h00);
		`CHK("master reset", 8'h00, q & 8'hf1)
		bus(1'h0, 1'h0, 8'h14);
		$display("overrun and reset done");
		end_of_test;
	end
endmodule // sacs_top_test
`default_nettype wire
